// ==== fault_frame_and_thermal_shutdown.sv ====
// Thermal shutdown supervisor and serial fault frame generator
//
// What this block does
// RULE_01 - Above upper thermal limit, shut chip down and float every PWM output.
// RULE_02 - Thermal detection armed only with valid regulator and any channel enable.
// RULE_03 - Below recovery limit, recover unaided and run a normal power-up.
// RULE_04 - Repeating fixed-period frame: alert portion plus one flag portion per channel.
// RULE_05 - Flags of faults that happened are high, others low.
// RULE_06 - Frames start when a fault confirms, stop after power-good returns.
// RULE_07 - A frame running when power-good returns is always finished.
// RULE_08 - Overcurrent confirmed when all used phases trip over nine consecutive cycles.
// RULE_09 - Order: alert, channel one flags, channel two flags, equal portions.
`timescale 1ns/1ps
module fault_frame_and_thermal_shutdown #(
	parameter int FRAME_CYCLES = fault_pkg::FRAME_CYCLES
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic internalRegulatorSupply,
	input wire logic channelOneEnable,
	input wire logic channelTwoEnable,
	input wire logic dieAboveUpper,
	input wire logic dieBelowRecovery,
	input wire logic [fault_pkg::NUM_CH-1:0] switchCycle,
	input wire fault_pkg::ch_fault_in_t chOne,
	input wire fault_pkg::ch_fault_in_t chTwo,
	input wire logic powerGoodIndication,
	output logic thermalShutdown,
	output logic powerUpRequest,
	output logic pwmOutEnableN,
	output logic [fault_pkg::NUM_CH-1:0] ocConfirmed,
	output logic faultOut,
	output logic frameActive
);

	localparam int PORTION = FRAME_CYCLES / 3;
	localparam int SLOT = PORTION / fault_pkg::FLAGS_PER_CH;

	// ----------------------------------------
	// Thermal shutdown
	// ----------------------------------------
	logic tsdArmed;
	assign tsdArmed = internalRegulatorSupply && (channelOneEnable || channelTwoEnable); // RULE_02

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			thermalShutdown <= 1'b0;
		end else if (!thermalShutdown && tsdArmed && dieAboveUpper) begin
			thermalShutdown <= 1'b1; // RULE_01
		end else if (thermalShutdown && dieBelowRecovery) begin
			thermalShutdown <= 1'b0; // RULE_03
		end
	end

	// Output enable is active low: high floats the PWM pins
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pwmOutEnableN <= 1'b1;
		end else begin
			pwmOutEnableN <= thermalShutdown || (tsdArmed && dieAboveUpper); // RULE_01
		end
	end

	// One-cycle request to restart the power sequence after cooling
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			powerUpRequest <= 1'b0;
		end else begin
			powerUpRequest <= thermalShutdown && dieBelowRecovery; // RULE_03
		end
	end

	// ----------------------------------------
	// Overcurrent confirmation per channel
	// ----------------------------------------
	fault_pkg::ch_fault_in_t chIn [fault_pkg::NUM_CH];
	assign chIn[0] = chOne;
	assign chIn[1] = chTwo;

	logic frameEnd;
	logic stopNow;

	genvar g;
	generate
		for (g = 0; g < fault_pkg::NUM_CH; g++) begin : gCh
			overcurrent_confirm #(
				.PHASES(fault_pkg::NUM_PHASES),
				.LIMIT(fault_pkg::OC_CYCLE_LIMIT)
			) uOc (
				.clk(clk),
				.sys_rst(sys_rst),
				.switchCycle(switchCycle[g]),
				.overcurrentTrip(chIn[g].overcurrentTrip),
				.phaseUsed(chIn[g].phaseUsed),
				.clear(stopNow),
				.confirmed(ocConfirmed[g])
			);
		end
	endgenerate

	// ----------------------------------------
	// Latched fault flags
	// ----------------------------------------
	fault_pkg::ch_flags_t flags_q [fault_pkg::NUM_CH];
	logic anyFault;

	generate
		for (g = 0; g < fault_pkg::NUM_CH; g++) begin : gFlag
			always_ff @(posedge clk) begin
				if (sys_rst) begin
					flags_q[g] <= '0;
				end else begin
					// Voltage and temperature sets win over the end-of-transmission clear; the overcurrent clear wins
					// Confirm level is stale at stop; a fresh one re-raises a cycle later
					flags_q[g][fault_pkg::FLAG_OC] <= (ocConfirmed[g] ||
						flags_q[g][fault_pkg::FLAG_OC]) && !stopNow; // RULE_05
					flags_q[g][fault_pkg::FLAG_OV] <= chIn[g].overVoltage ||
						(flags_q[g][fault_pkg::FLAG_OV] && !stopNow);
					flags_q[g][fault_pkg::FLAG_UV] <= chIn[g].underVoltage ||
						(flags_q[g][fault_pkg::FLAG_UV] && !stopNow);
					flags_q[g][fault_pkg::FLAG_OT] <= chIn[g].overTemp ||
						(flags_q[g][fault_pkg::FLAG_OT] && !stopNow);
				end
			end
		end
	endgenerate

	assign anyFault = (|flags_q[0]) || (|flags_q[1]) || thermalShutdown;

	// ----------------------------------------
	// Frame sequencer
	// ----------------------------------------
	fault_pkg::frame_state_t state_q;
	logic [fault_pkg::CNT_W-1:0] cnt_q;
	logic pgSeen_q;

	assign frameEnd = (state_q == fault_pkg::FR_SEND) &&
		(cnt_q == fault_pkg::CNT_W'(FRAME_CYCLES - 1));
	// Stop only at a frame boundary, never mid-frame
	assign stopNow = frameEnd && (pgSeen_q || powerGoodIndication); // RULE_07

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_q <= fault_pkg::FR_IDLE;
		end else begin
			case (state_q)
				fault_pkg::FR_IDLE: begin
					if (anyFault) begin
						state_q <= fault_pkg::FR_SEND; // RULE_06
					end
				end
				fault_pkg::FR_SEND: begin
					if (stopNow) begin
						state_q <= fault_pkg::FR_IDLE; // RULE_06
					end
				end
				default: begin
					state_q <= fault_pkg::FR_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst || state_q != fault_pkg::FR_SEND || frameEnd) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_q + fault_pkg::CNT_W'(1); // RULE_04
		end
	end

	// Power-good must be seen high while frames are being sent to end transmission
	always_ff @(posedge clk) begin
		if (sys_rst || state_q == fault_pkg::FR_IDLE || stopNow) begin
			pgSeen_q <= 1'b0;
		end else if (powerGoodIndication) begin
			pgSeen_q <= 1'b1; // RULE_06
		end
	end

	// ----------------------------------------
	// Serial output
	// ----------------------------------------
	logic faultBit;
	logic [fault_pkg::CNT_W-1:0] inPortion;
	logic [fault_pkg::CNT_W-1:0] slotIdx;

	always_comb begin
		faultBit = 1'b0;
		inPortion = '0;
		slotIdx = '0;
		if (state_q == fault_pkg::FR_SEND) begin
			if (cnt_q < fault_pkg::CNT_W'(PORTION)) begin
				faultBit = 1'b1; // RULE_09
			end else if (cnt_q < fault_pkg::CNT_W'(2 * PORTION)) begin
				inPortion = cnt_q - fault_pkg::CNT_W'(PORTION);
				slotIdx = inPortion / fault_pkg::CNT_W'(SLOT);
				if (slotIdx < fault_pkg::CNT_W'(fault_pkg::FLAGS_PER_CH)) begin
					faultBit = flags_q[0][slotIdx[1:0]]; // RULE_05
				end
			end else begin
				inPortion = cnt_q - fault_pkg::CNT_W'(2 * PORTION);
				slotIdx = inPortion / fault_pkg::CNT_W'(SLOT);
				if (slotIdx < fault_pkg::CNT_W'(fault_pkg::FLAGS_PER_CH)) begin
					faultBit = flags_q[1][slotIdx[1:0]]; // RULE_09
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			faultOut <= 1'b0;
			frameActive <= 1'b0;
		end else begin
			faultOut <= faultBit; // RULE_04
			frameActive <= (state_q == fault_pkg::FR_SEND);
		end
	end

endmodule

// ==== fault_pkg.sv ====
// Shared constants and carrier types for the fault frame and thermal supervisor
package fault_pkg;

	// ----------------------------------------
	// Sizes
	// ----------------------------------------
	localparam int NUM_CH = 2;
	localparam int NUM_PHASES = 4;
	localparam int FLAGS_PER_CH = 4;
	localparam int OC_CYCLE_LIMIT = 8;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_MHZ = 125;
	localparam int FRAME_PERIOD_US = 36;
	localparam int FRAME_CYCLES = FRAME_PERIOD_US * CLK_MHZ;
	localparam int PORTION_CYCLES = FRAME_CYCLES / 3;
	localparam int FLAG_SLOT_CYCLES = PORTION_CYCLES / FLAGS_PER_CH;
	localparam int CNT_W = 13;

	// ----------------------------------------
	// Flag positions inside one channel portion
	// ----------------------------------------
	localparam int FLAG_OC = 0;
	localparam int FLAG_OV = 1;
	localparam int FLAG_UV = 2;
	localparam int FLAG_OT = 3;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef struct packed {
		logic [NUM_PHASES-1:0] overcurrentTrip;
		logic [NUM_PHASES-1:0] phaseUsed;
		logic overVoltage;
		logic underVoltage;
		logic overTemp;
	} ch_fault_in_t;

	typedef logic [FLAGS_PER_CH-1:0] ch_flags_t;

	typedef enum logic [1:0] {
		FR_IDLE,
		FR_SEND
	} frame_state_t;

endpackage

// ==== overcurrent_confirm.sv ====
// Per-channel overcurrent confirmation over consecutive switching cycles
`timescale 1ns/1ps
module overcurrent_confirm #(
	parameter int PHASES = fault_pkg::NUM_PHASES,
	parameter int LIMIT = fault_pkg::OC_CYCLE_LIMIT
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic switchCycle,
	input wire logic [PHASES-1:0] overcurrentTrip,
	input wire logic [PHASES-1:0] phaseUsed,
	input wire logic clear,
	output logic confirmed
);

	logic [4:0] run_q;
	logic allTrip;

	// Unused phases count as tripping so a single-phase rail still confirms
	assign allTrip = &(overcurrentTrip | ~phaseUsed) && (|phaseUsed);

	always_ff @(posedge clk) begin
		if (sys_rst || clear) begin
			run_q <= 5'h00;
		end else if (switchCycle) begin
			if (!allTrip) begin
				run_q <= 5'h00;
			end else if (run_q <= 5'(LIMIT)) begin
				run_q <= run_q + 5'h01;
			end
		end
	end

	// A fresh confirmation outranks the end-of-transmission clear
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			confirmed <= 1'b0;
		end else if (switchCycle && allTrip && run_q >= 5'(LIMIT)) begin
			confirmed <= 1'b1; // RULE_08
		end else if (clear) begin
			confirmed <= 1'b0;
		end
	end

endmodule

// ==== fault_frame_assertions.sv ====
// Port-level checks on the thermal supervisor and fault frame
`timescale 1ns/1ps
module fault_frame_assertions #(
	parameter int FRAME_CYCLES = 48
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic internalRegulatorSupply,
	input wire logic channelOneEnable,
	input wire logic channelTwoEnable,
	input wire logic dieAboveUpper,
	input wire logic dieBelowRecovery,
	input wire logic thermalShutdown,
	input wire logic powerUpRequest,
	input wire logic pwmOutEnableN,
	input wire logic faultOut,
	input wire logic frameActive
);
	logic armed;
	int runQ;
	assign armed = internalRegulatorSupply && (channelOneEnable || channelTwoEnable);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	// Length of the current run of frames
	always_ff @(posedge clk) begin
		runQ <= (sys_rst || !frameActive) ? 0 : runQ + 1;
	end
	chk_hot_trip: assert property (
		armed && dieAboveUpper |=> thermalShutdown && pwmOutEnableN) else $error("no trip");
	chk_unarmed_hold: assert property (
		!thermalShutdown && !armed |=> !thermalShutdown) else $error("unarmed trip");
	chk_cool_recover: assert property (
		thermalShutdown && dieBelowRecovery |=> !thermalShutdown && powerUpRequest)
		else $error("no recovery");
	chk_powerup_pulse: assert property (
		powerUpRequest |-> $past(thermalShutdown) ##1 !powerUpRequest) else $error("bad pulse");
	chk_pwm_float: assert property (
		thermalShutdown |-> pwmOutEnableN) else $error("pwm not floated");
	chk_alert_first: assert property (
		$rose(frameActive) |-> faultOut [*8]) else $error("alert missing");
	chk_whole_frame: assert property (
		$fell(frameActive) |-> runQ % FRAME_CYCLES == 0) else $error("frame cut");
	chk_idle_low: assert property (
		!frameActive |-> !faultOut) else $error("idle not low");
endmodule
bind fault_frame_and_thermal_shutdown fault_frame_assertions #(
	.FRAME_CYCLES(FRAME_CYCLES)
) u_chk (
	.clk, .sys_rst, .internalRegulatorSupply, .channelOneEnable, .channelTwoEnable,
	.dieAboveUpper, .dieBelowRecovery, .thermalShutdown, .powerUpRequest,
	.pwmOutEnableN, .faultOut, .frameActive
);

// ==== fault_monitor.sv ====
// Supervisor model sampling each fault frame in the middle of every slot
`timescale 1ns/1ps
module fault_monitor #(
	parameter int FRAME_CYCLES = 48
) (
	input wire logic clk,
	input wire logic faultOut,
	input wire logic frameActive,
	output logic [11:0] slotBits,
	output int frames
);
	localparam int SLOT = FRAME_CYCLES / 12;
	int cnt = 0;
	int frameCnt = 0;
	assign frames = frameCnt;
	always @(posedge clk) begin
		if (!frameActive) begin
			cnt <= 0;
		end else begin
			// Mid-slot sample keeps clear of the one-cycle lag
			if (cnt % SLOT == SLOT / 2) begin
				slotBits[cnt / SLOT] <= faultOut;
			end
			cnt <= (cnt == FRAME_CYCLES - 1) ? 0 : cnt + 1;
			if (cnt == FRAME_CYCLES - 1) begin
				frameCnt <= frameCnt + 1;
			end
		end
	end
endmodule

// ==== tb_fault_frame_and_thermal_shutdown.sv ====
// Self-checking bench for the thermal supervisor and fault frame
`timescale 1ns/1ps
module tb_fault_frame_and_thermal_shutdown;
	localparam int FC = 48;
	typedef struct {logic [5:0] in; logic [11:0] exp;} row_t;
	row_t rows [7] = '{'{6'h01, 12'h02F}, '{6'h02, 12'h04F}, '{6'h04, 12'h08F},
		'{6'h08, 12'h20F}, '{6'h10, 12'h40F}, '{6'h20, 12'h80F}, '{6'h3F, 12'hEEF}};
	logic clk = 0;
	logic sysRst = 1;
	logic regOk = 1;
	logic en1 = 1;
	logic en2 = 0;
	logic hot = 0;
	logic cool = 0;
	logic pg = 0;
	logic [1:0] sw = '0;
	fault_pkg::ch_fault_in_t c1 = '0;
	fault_pkg::ch_fault_in_t c2 = '0;
	logic thermal_shutdown, pup, pwmN, fo, fa;
	logic [1:0] oc;
	logic [11:0] slots;
	int frames;
	int miscompares = 0;
	int n_checks = 0;
	always #4 clk = ~clk;
	fault_frame_and_thermal_shutdown #(.FRAME_CYCLES(FC)) u_dut (.clk(clk), .sys_rst(sysRst),
		.internalRegulatorSupply(regOk), .channelOneEnable(en1), .channelTwoEnable(en2),
		.dieAboveUpper(hot), .dieBelowRecovery(cool), .switchCycle(sw), .chOne(c1),
		.chTwo(c2), .powerGoodIndication(pg), .thermalShutdown(thermal_shutdown), .powerUpRequest(pup),
		.pwmOutEnableN(pwmN), .ocConfirmed(oc), .faultOut(fo), .frameActive(fa));
	fault_monitor #(.FRAME_CYCLES(FC)) u_mon (.clk(clk), .faultOut(fo), .frameActive(fa),
		.slotBits(slots), .frames(frames));
	task automatic chkBit(input string n, input logic e, input logic g);
		n_checks++;
		if (g !== e) begin
			miscompares++;
			$display("ERROR %s exp %b got %b", n, e, g);
		end
	endtask
	task automatic chkVec(input string n, input logic [11:0] e, input logic [11:0] g);
		n_checks++;
		if (g !== e) begin
			miscompares++;
			$display("ERROR %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic waitFa(input logic lvl);
		for (int i = 0; i < 4 * FC && fa !== lvl; i++) @(posedge clk);
		if (fa !== lvl) begin
			miscompares++;
			tally_and_finish();
		end
	endtask
	task automatic setFaults(input logic [5:0] v);
		c1.overVoltage <= v[0];
		c1.underVoltage <= v[1];
		c1.overTemp <= v[2];
		c2.overVoltage <= v[3];
		c2.underVoltage <= v[4];
		c2.overTemp <= v[5];
	endtask
	// Power good returns early in the frame; exactly one whole frame must follow
	task automatic runFrame(input logic [5:0] v, input logic [11:0] exp);
		int f0;
		setFaults(v);
		waitFa(1);
		f0 = frames;
		@(posedge clk);
		pg <= 1;
		setFaults(6'h00);
		waitFa(0);
		chkVec("slots", exp, slots);
		chkBit("oneFrame", 1, frames - f0 == 1);
		pg <= 0;
		@(posedge clk);
		$display("frame test done");
	endtask
	task automatic ocPulses(input int n, input logic [3:0] trip);
		repeat (n) begin
			c1.overcurrentTrip <= trip;
			c2.overcurrentTrip <= trip;
			sw <= 2'h3;
			@(posedge clk);
			sw <= 2'h0;
			@(posedge clk);
		end
	endtask
	initial begin
		repeat (10) @(posedge clk);
		sysRst <= 0;
		@(posedge clk);
		foreach (rows[i]) runFrame(rows[i].in, rows[i].exp);
		// Unused phase 2 trips too; one miss restarts the run
		// Channel two uses all four phases, so partial trips never confirm
		c1.phaseUsed <= 4'h3;
		c2.phaseUsed <= 4'hF;
		ocPulses(5, 4'h7);
		ocPulses(1, 4'h1);
		ocPulses(8, 4'h3);
		chkBit("oc8", 0, oc[0]);
		ocPulses(1, 4'h3);
		@(posedge clk);
		chkBit("oc9", 1, oc[0]);
		chkBit("ocPart", 0, oc[1]);
		c1.overcurrentTrip <= 4'h0;
		c2.overcurrentTrip <= 4'h0;
		runFrame(6'h00, 12'h01F);
		chkBit("ocClear", 0, oc[0]);
		ocPulses(9, 4'hF);
		runFrame(6'h00, 12'h11F);
		chkBit("ocBothClear", 0, oc[0] | oc[1]);
		$display("oc test done");
		regOk <= 0;
		hot <= 1;
		repeat (3) @(posedge clk);
		chkBit("unarmed", 0, thermal_shutdown);
		chkBit("unarmedPwm", 0, pwmN);
		regOk <= 1;
		en1 <= 0;
		en2 <= 1;
		repeat (2) @(posedge clk);
		chkBit("tsd", 1, thermal_shutdown);
		chkBit("float", 1, pwmN);
		hot <= 0;
		cool <= 1;
		repeat (2) @(posedge clk);
		chkBit("recover", 0, thermal_shutdown);
		chkBit("powerUp", 1, pup);
		cool <= 0;
		@(posedge clk);
		chkBit("pulse", 0, pup);
		// Pins come back one cycle after the shutdown flag drops
		chkBit("drive", 0, pwmN);
		$display("thermal test done");
		runFrame(6'h00, 12'h00F);
		setFaults(6'h08);
		waitFa(1);
		// Power good stays low, so frames must keep coming back to back
		setFaults(6'h00);
		repeat (2 * FC) @(posedge clk);
		chkBit("pgLowRuns", 1, fa);
		sysRst <= 1;
		repeat (2) @(posedge clk);
		chkBit("rstFa", 0, fa);
		chkBit("rstFo", 0, fo);
		chkBit("rstPwm", 1, pwmN);
		$display("reset test done");
		tally_and_finish();
	end
endmodule
